/* verilog/accel_regs_pkg.sv */
package accel_regs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_VENDOR_CODE = 8'h00;
  localparam logic [7:0] ADDR_FAMILY_CODE = 8'h01;
  localparam logic [7:0] ADDR_PART_CODE = 8'h02;
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'h03;
  localparam logic [7:0] ADDR_X_AXIS_BYTE = 8'h08;
  localparam logic [7:0] ADDR_Y_AXIS_BYTE = 8'h09;
  localparam logic [7:0] ADDR_Z_AXIS_BYTE = 8'h0a;
  localparam logic [7:0] ADDR_CONDITION_FLAGS = 8'h0b;
  localparam logic [7:0] ADDR_SOFTWARE_RESET = 8'h1f;
  localparam logic [7:0] ADDR_MOTION_THRESHOLD_LOW = 8'h20;
  localparam logic [7:0] ADDR_MOTION_THRESHOLD_HIGH = 8'h21;
  localparam logic [7:0] ADDR_MOTION_TIME = 8'h22;
  localparam logic [7:0] ADDR_STILLNESS_THRESHOLD_LOW = 8'h23;
  localparam logic [7:0] ADDR_STILLNESS_THRESHOLD_HIGH = 8'h24;
  localparam logic [7:0] ADDR_STILLNESS_TIME_LOW = 8'h25;
  localparam logic [7:0] ADDR_STILLNESS_TIME_HIGH = 8'h26;
  localparam logic [7:0] ADDR_DETECTION_CONTROL = 8'h27;
  localparam logic [7:0] ADDR_BUFFER_CONTROL = 8'h28;
  localparam logic [7:0] ADDR_BUFFER_LEVEL_SETTING = 8'h29;
  localparam logic [7:0] ADDR_IRQ_PIN1_MAP = 8'h2a;
  localparam logic [7:0] ADDR_IRQ_PIN2_MAP = 8'h2b;
  localparam logic [7:0] ADDR_FILTER_CONFIG = 8'h2c;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h2d;
  localparam logic [7:0] ADDR_SELF_CHECK = 8'h2e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_CONDITION_FLAGS = 8'h40;
  localparam logic [7:0] RESET_BUFFER_LEVEL_SETTING = 8'h80;
  localparam logic [7:0] RESET_FILTER_CONFIG = 8'h13;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h52;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int FLAG_REG_ERROR = 7;
  localparam int FLAG_AWAKE = 6;
  localparam int FLAG_STILLNESS = 5;
  localparam int FLAG_MOTION = 4;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_LEVEL = 2;
  localparam int FLAG_NONEMPTY = 1;
  localparam int FLAG_NEW_SAMPLE = 0;
  localparam int DET_CHAINED = 4;
  localparam int DET_CYCLIC = 5;
  localparam int BUF_LEVEL_MSB = 3;
  localparam int MAP_ACTIVE_LOW = 7;
  localparam int THRESHOLD_HIGH_BITS = 3;
  localparam int BUFFER_COUNT_WIDTH = 10;

endpackage

/* verilog/irq_pin_map.sv */
`timescale 1ns/100ps
module irq_pin_map (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] pinMap,
  input wire logic [7:0] conditionFlags,
  output logic irqPin
);
  import accel_regs_pkg::*;

  logic [6:0] routed;
  logic [6:0] next_routed;

  // ****************************************
  // Per-condition routing
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_route
      assign next_routed[i] = pinMap[i] & conditionFlags[i]; // RL18
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      routed <= 7'h00;
    end else begin
      routed <= next_routed;
    end
  end

  // Pin driven from its own flop; polarity applies when idle too
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqPin <= 1'b0;
    end else begin
      irqPin <= (|routed) ^ pinMap[MAP_ACTIVE_LOW]; // RL18
    end
  end

endmodule

/* verilog/accel_config_status_regs.sv */
`timescale 1ns/100ps
// Notes on behaviour
// (RL1) Every user register takes its default value on reset, before any access.
// (RL2) Host changes registers up to filter_config only while in standby.
// (RL3) Silicon revision reads a code starting at one value, rising per revision.
// (RL4) Each axis byte register returns the top eight bits of its axis sample.
// (RL5) Status bit 7 sets on a register upset or while still unconfigured.
// (RL6) Register-error flag is high after startup and soft reset; any write clears it.
// (RL7) Status bit 6 shows awake state from the detection function.
// (RL8) Outside chained or cyclic detection the awake flag is held at one.
// (RL9) Status bit 5 sets when stillness or free fall is detected.
// (RL10) Motion flag sets when motion detection finds an over-threshold condition.
// (RL11) Overflow flag sets when the buffer overflows and replaces unread samples.
// (RL12) Level flag is set while the buffer holds at least the programmed count.
// (RL13) Nonempty flag is set while at least one sample is buffered.
// (RL14) New-sample flag sets when a new valid sample becomes readable.
// (RL15) New-sample flag clears when the host performs a buffer read.
// (RL16) After reset the status register reads with only the awake flag set; the code also sets the error flag, giving 0xC0.
// (RL17) Writing the reset code clears all settings to standby; reads return zero.
// (RL18) Each pin map routes chosen conditions to its pin; top bit selects active low.
module accel_config_status_regs #(
  parameter int AXIS_WIDTH = 12,
  parameter logic [7:0] VENDOR_VALUE = 8'h5a,
  parameter logic [7:0] FAMILY_VALUE = 8'h3c,
  parameter logic [7:0] PART_VALUE = 8'h77,
  parameter logic [7:0] REVISION_VALUE = 8'h02
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic [AXIS_WIDTH-1:0] xSample,
  input wire logic [AXIS_WIDTH-1:0] ySample,
  input wire logic [AXIS_WIDTH-1:0] zSample,
  input wire logic newSample,
  input wire logic bufferRead,
  input wire logic [accel_regs_pkg::BUFFER_COUNT_WIDTH-1:0] bufferCount,
  input wire logic bufferOverflow,
  input wire logic motionEvent,
  input wire logic stillnessEvent,
  input wire logic awakeState,
  input wire logic singleEventUpset,
  output logic [7:0] motion_threshold_low,
  output logic [7:0] motion_threshold_high,
  output logic [7:0] motion_time,
  output logic [7:0] stillness_threshold_low,
  output logic [7:0] stillness_threshold_high,
  output logic [7:0] stillness_time_low,
  output logic [7:0] stillness_time_high,
  output logic [7:0] detection_control,
  output logic [7:0] buffer_control,
  output logic [7:0] buffer_level_setting,
  output logic [7:0] filter_config,
  output logic [7:0] power_control,
  output logic [7:0] self_check,
  output logic softResetPulse,
  output logic irqPin1,
  output logic irqPin2
);
  import accel_regs_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  generate
    if (AXIS_WIDTH < 8) begin : g_bad_width
      $error("AXIS_WIDTH must be at least 8");
    end
  endgenerate

  // ****************************************
  // Decode
  // ****************************************
  logic writeStrobe;
  logic softResetHit;
  logic statusRead;
  logic [7:0] irq_pin1_map;
  logic [7:0] irq_pin2_map;
  logic [7:0] condition_flags;
  logic [7:0] axisByte [3];
  logic [AXIS_WIDTH-1:0] axisSample [3];
  logic regError;
  logic awakeFlag;
  logic stillnessFlag;
  logic motionFlag;
  logic overflowFlag;
  logic levelFlag;
  logic nonemptyFlag;
  logic newSampleFlag;
  logic [8:0] levelSetting;
  logic [7:0] next_readData;

  assign writeStrobe = regWrite;
  // Soft reset only on the exact code; other values are plain writes
  assign softResetHit = regWrite && (regAddr == ADDR_SOFTWARE_RESET)
      && (regWriteData == SOFT_RESET_CODE); // RL17
  assign statusRead = regRead && (regAddr == ADDR_CONDITION_FLAGS);
  assign levelSetting = {buffer_control[BUF_LEVEL_MSB], buffer_level_setting};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= softResetHit; // RL17
    end
  end

  // ****************************************
  // Writable settings
  // ****************************************
  // Writes are taken in any mode; keeping to standby is the host's duty (RL2)
  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin // RL1 RL17
      motion_threshold_low <= RESET_ZERO;
      motion_threshold_high <= RESET_ZERO;
      motion_time <= RESET_ZERO;
      stillness_threshold_low <= RESET_ZERO;
      stillness_threshold_high <= RESET_ZERO;
      stillness_time_low <= RESET_ZERO;
      stillness_time_high <= RESET_ZERO;
      detection_control <= RESET_ZERO;
      buffer_control <= RESET_ZERO;
      buffer_level_setting <= RESET_BUFFER_LEVEL_SETTING;
      irq_pin1_map <= RESET_ZERO;
      irq_pin2_map <= RESET_ZERO;
      filter_config <= RESET_FILTER_CONFIG;
      power_control <= RESET_ZERO;
      self_check <= RESET_ZERO;
    end else if (writeStrobe) begin
      unique case (regAddr)
        ADDR_MOTION_THRESHOLD_LOW: begin
          motion_threshold_low <= regWriteData;
        end
        ADDR_MOTION_THRESHOLD_HIGH: begin
          motion_threshold_high <= {5'h00, regWriteData[THRESHOLD_HIGH_BITS-1:0]};
        end
        ADDR_MOTION_TIME: begin
          motion_time <= regWriteData;
        end
        ADDR_STILLNESS_THRESHOLD_LOW: begin
          stillness_threshold_low <= regWriteData;
        end
        ADDR_STILLNESS_THRESHOLD_HIGH: begin
          stillness_threshold_high <= {5'h00, regWriteData[THRESHOLD_HIGH_BITS-1:0]};
        end
        ADDR_STILLNESS_TIME_LOW: begin
          stillness_time_low <= regWriteData;
        end
        ADDR_STILLNESS_TIME_HIGH: begin
          stillness_time_high <= regWriteData;
        end
        ADDR_DETECTION_CONTROL: begin
          detection_control <= regWriteData;
        end
        ADDR_BUFFER_CONTROL: begin
          buffer_control <= {4'h0, regWriteData[3:0]};
        end
        ADDR_BUFFER_LEVEL_SETTING: begin
          buffer_level_setting <= regWriteData;
        end
        ADDR_IRQ_PIN1_MAP: begin
          irq_pin1_map <= regWriteData;
        end
        ADDR_IRQ_PIN2_MAP: begin
          irq_pin2_map <= regWriteData;
        end
        ADDR_FILTER_CONFIG: begin
          filter_config <= regWriteData;
        end
        ADDR_POWER_CONTROL: begin
          power_control <= regWriteData;
        end
        ADDR_SELF_CHECK: begin
          self_check <= {7'h00, regWriteData[0]};
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Axis bytes
  // ****************************************
  assign axisSample[0] = xSample;
  assign axisSample[1] = ySample;
  assign axisSample[2] = zSample;

  // Captured with the sample so the three bytes stay coherent
  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      always_ff @(posedge core_clk) begin
        if (srst) begin
          axisByte[a] <= RESET_ZERO;
        end else if (newSample) begin
          axisByte[a] <= axisSample[a][AXIS_WIDTH-1 -: 8]; // RL4
        end
      end
    end
  endgenerate

  // ****************************************
  // Condition flags
  // ****************************************
  // Upset beats a clearing write, soft reset beats both
  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      regError <= 1'b1; // RL6
    end else if (singleEventUpset) begin
      regError <= 1'b1; // RL5
    end else if (writeStrobe) begin
      regError <= 1'b0; // RL6
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      awakeFlag <= 1'b1; // RL16
    end else if (detection_control[DET_CHAINED] || detection_control[DET_CYCLIC]) begin
      awakeFlag <= awakeState; // RL7
    end else begin
      awakeFlag <= 1'b1; // RL8
    end
  end

  // Sticky event flags clear on a status read; a new event wins
  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      stillnessFlag <= 1'b0;
    end else if (stillnessEvent) begin
      stillnessFlag <= 1'b1; // RL9
    end else if (statusRead) begin
      stillnessFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      motionFlag <= 1'b0;
    end else if (motionEvent) begin
      motionFlag <= 1'b1; // RL10
    end else if (statusRead) begin
      motionFlag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      overflowFlag <= 1'b0;
    end else if (bufferOverflow) begin
      overflowFlag <= 1'b1; // RL11
    end else if (statusRead) begin
      overflowFlag <= 1'b0;
    end
  end

  // Level flags follow the count; they lag it by one cycle
  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      levelFlag <= 1'b0;
      nonemptyFlag <= 1'b0;
    end else begin
      levelFlag <= bufferCount >= {1'b0, levelSetting}; // RL12
      nonemptyFlag <= bufferCount != '0; // RL13
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || softResetHit) begin
      newSampleFlag <= 1'b0;
    end else if (newSample) begin
      newSampleFlag <= 1'b1; // RL14
    end else if (bufferRead) begin
      newSampleFlag <= 1'b0; // RL15
    end
  end

  // Reset view is awake only; error bit joins it as required on startup
  assign condition_flags = {regError, awakeFlag, stillnessFlag, motionFlag,
      overflowFlag, levelFlag, nonemptyFlag, newSampleFlag}; // RL16

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    next_readData = RESET_ZERO;
    unique case (regAddr)
      ADDR_VENDOR_CODE: next_readData = VENDOR_VALUE;
      ADDR_FAMILY_CODE: next_readData = FAMILY_VALUE;
      ADDR_PART_CODE: next_readData = PART_VALUE;
      ADDR_SILICON_REVISION: next_readData = REVISION_VALUE; // RL3
      ADDR_X_AXIS_BYTE: next_readData = axisByte[0]; // RL4
      ADDR_Y_AXIS_BYTE: next_readData = axisByte[1]; // RL4
      ADDR_Z_AXIS_BYTE: next_readData = axisByte[2]; // RL4
      ADDR_CONDITION_FLAGS: next_readData = condition_flags;
      ADDR_SOFTWARE_RESET: next_readData = RESET_ZERO; // RL17
      ADDR_MOTION_THRESHOLD_LOW: next_readData = motion_threshold_low;
      ADDR_MOTION_THRESHOLD_HIGH: next_readData = motion_threshold_high;
      ADDR_MOTION_TIME: next_readData = motion_time;
      ADDR_STILLNESS_THRESHOLD_LOW: next_readData = stillness_threshold_low;
      ADDR_STILLNESS_THRESHOLD_HIGH: next_readData = stillness_threshold_high;
      ADDR_STILLNESS_TIME_LOW: next_readData = stillness_time_low;
      ADDR_STILLNESS_TIME_HIGH: next_readData = stillness_time_high;
      ADDR_DETECTION_CONTROL: next_readData = detection_control;
      ADDR_BUFFER_CONTROL: next_readData = buffer_control;
      ADDR_BUFFER_LEVEL_SETTING: next_readData = buffer_level_setting;
      ADDR_IRQ_PIN1_MAP: next_readData = irq_pin1_map;
      ADDR_IRQ_PIN2_MAP: next_readData = irq_pin2_map;
      ADDR_FILTER_CONFIG: next_readData = filter_config;
      ADDR_POWER_CONTROL: next_readData = power_control;
      ADDR_SELF_CHECK: next_readData = self_check;
      default: next_readData = RESET_ZERO;
    endcase
  end

  // Data holds until the next read, so a slow serial shifter can take it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      regReadData <= RESET_ZERO;
    end else if (regRead) begin
      regReadData <= next_readData;
    end
  end

  // ****************************************
  // Interrupt pins
  // ****************************************
  irq_pin_map u_pin1 (
    .core_clk(core_clk),
    .srst(srst),
    .pinMap(irq_pin1_map),
    .conditionFlags(condition_flags),
    .irqPin(irqPin1)
  );

  irq_pin_map u_pin2 (
    .core_clk(core_clk),
    .srst(srst),
    .pinMap(irq_pin2_map),
    .conditionFlags(condition_flags),
    .irqPin(irqPin2)
  );

endmodule

/* sim/accel_regs_properties.sv */
`timescale 1ns/100ps
module accel_regs_checker #(
  parameter int AXIS_WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic [AXIS_WIDTH-1:0] xSample,
  input wire logic newSample,
  input wire logic bufferRead,
  input wire logic [accel_regs_pkg::BUFFER_COUNT_WIDTH-1:0] bufferCount,
  input wire logic singleEventUpset,
  input wire logic [7:0] detection_control,
  input wire logic [7:0] buffer_control,
  input wire logic [7:0] buffer_level_setting,
  input wire logic [7:0] filter_config,
  input wire logic softResetPulse
);
  import accel_regs_pkg::*;
  logic statusRead;
  logic resetWrite;
  assign statusRead = regRead && regAddr == ADDR_CONDITION_FLAGS;
  assign resetWrite = regWrite && regAddr == ADDR_SOFTWARE_RESET
    && regWriteData == SOFT_RESET_CODE;
  // Top byte of the last captured x sample, kept apart from the design
  logic [7:0] lastTop;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lastTop <= 8'h00;
    end else if (newSample) begin
      lastTop <= xSample[AXIS_WIDTH-1 -: 8];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // ****************************************
  // Settings and soft reset
  // ****************************************
  reset_defaults_a: assert property (
    $fell(srst) |-> filter_config == RESET_FILTER_CONFIG
      && buffer_level_setting == RESET_BUFFER_LEVEL_SETTING)
    else $error("Settings not at defaults after reset");
  soft_reset_apply_a: assert property (
    resetWrite |=> softResetPulse && filter_config == RESET_FILTER_CONFIG
      && buffer_level_setting == RESET_BUFFER_LEVEL_SETTING)
    else $error("Soft reset did not restore settings");
  soft_reset_read_a: assert property (
    regRead && regAddr == ADDR_SOFTWARE_RESET |=> regReadData == 8'h00)
    else $error("Soft reset register read not zero");

  // ****************************************
  // Status flags
  // ****************************************
  error_clear_a: assert property (
    regWrite && !resetWrite && !singleEventUpset ##1 !singleEventUpset && !regWrite
      ##1 statusRead |=> !regReadData[7])
    else $error("Error flag not cleared by write");
  upset_flag_a: assert property (
    singleEventUpset ##1 !regWrite ##1 statusRead |=> regReadData[7])
    else $error("Error flag not set by upset");
  axis_top_a: assert property (
    regRead && regAddr == ADDR_X_AXIS_BYTE |=> regReadData == $past(lastTop))
    else $error("Axis byte not top bits of sample");
  awake_default_a: assert property (
    statusRead && detection_control[5:4] == 2'b00
      && $past(detection_control[5:4]) == 2'b00 |=> regReadData[6])
    else $error("Awake flag not held high");
  level_flag_a: assert property (
    statusRead && $stable(bufferCount) && !$past(regWrite) |=> regReadData[2] ==
      ($past(bufferCount) >= {$past(buffer_control[3]), $past(buffer_level_setting)}))
    else $error("Level flag wrong");
  nonempty_flag_a: assert property (
    statusRead && $stable(bufferCount) && !$past(regWrite)
      |=> regReadData[1] == ($past(bufferCount) != 0))
    else $error("Nonempty flag wrong");
  ready_set_a: assert property (
    newSample ##1 !bufferRead && !regWrite ##1 statusRead |=> regReadData[0])
    else $error("New sample flag not set");
  ready_clear_a: assert property (
    bufferRead && !newSample ##1 !newSample ##1 statusRead |=> !regReadData[0])
    else $error("New sample flag not cleared");
endmodule

bind accel_config_status_regs accel_regs_checker #(.AXIS_WIDTH(AXIS_WIDTH)) u_chk (
  .core_clk, .srst, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData,
  .xSample, .newSample, .bufferRead, .bufferCount, .singleEventUpset,
  .detection_control, .buffer_control, .buffer_level_setting, .filter_config,
  .softResetPulse
);

/* sim/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input wire logic core_clk,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWriteData,
  output logic regRead,
  input wire logic [7:0] regReadData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWriteData = 8'h00;
    regRead = 1'b0;
  end

  // ****************************************
  // Strobe port access
  // ****************************************
  // Callers keep measurement off while writing low registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWriteData <= ~d;
  endtask

  // Released lines show inverted values so stale data cannot pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge core_clk);
    #1;
    d = regReadData;
  endtask
endmodule

/* sim/accel_config_status_regs_tb.sv */
`timescale 1ns/100ps
module accel_config_status_regs_tb;
  import accel_regs_pkg::*;
  // Identity codes below are arbitrary
  localparam logic [7:0] VEND_CODE = 8'h6b;
  localparam logic [7:0] REV_CODE = 8'h04;
  logic core_clk, srst, regWrite, regRead, awakeState, irqPin1, irqPin2;
  logic [7:0] regAddr, regWriteData, regReadData, rdVal, dflt, msk;
  logic [11:0] xSample, ySample, zSample;
  logic [5:0] ev;
  logic [9:0] bufferCount;
  logic [9:0] cnts [4] = '{10'h180, 10'h17f, 10'h001, 10'h000};
  logic [7:0] lvl [4] = '{8'h06, 8'h02, 8'h02, 8'h00};
  int nErrors, cmpCount;

  accel_config_status_regs #(.AXIS_WIDTH(12), .VENDOR_VALUE(VEND_CODE),
    .REVISION_VALUE(REV_CODE)) u_dut (
    .core_clk, .srst, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData,
    .xSample, .ySample, .zSample, .newSample(ev[0]), .bufferRead(ev[1]),
    .bufferCount, .bufferOverflow(ev[2]), .motionEvent(ev[3]),
    .stillnessEvent(ev[4]), .awakeState, .singleEventUpset(ev[5]),
    .motion_threshold_low(), .motion_threshold_high(), .motion_time(),
    .stillness_threshold_low(), .stillness_threshold_high(), .stillness_time_low(),
    .stillness_time_high(), .detection_control(), .buffer_control(),
    .buffer_level_setting(), .filter_config(), .power_control(), .self_check(),
    .softResetPulse(), .irqPin1, .irqPin2);
  host_model u_host (.core_clk, .regAddr, .regWrite, .regWriteData, .regRead,
    .regReadData);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk(input string nm, input logic [7:0] a, m, e);
    u_host.rd(a, rdVal);
    cmp(nm, e, rdVal & m);
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= 6'h00;
  endtask
  function automatic void regInfo(input logic [7:0] a);
    dflt = (a == 8'h29) ? 8'h80 : (a == 8'h2c) ? 8'h13 : 8'h00;
    msk = (a == 8'h21 || a == 8'h24) ? 8'h07 : (a == 8'h28) ? 8'h0f :
      (a == 8'h2e) ? 8'h01 : 8'hff;
  endfunction
  task automatic chkDefaults();
    for (int a = 32; a <= 46; a++) begin
      regInfo(8'(a));
      chk("setting", 8'(a), 8'hff, dflt);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    test_done();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    srst = 1'b1;
    ev = 6'h00;
    bufferCount = 10'h000;
    awakeState = 1'b0;
    xSample = 12'habc;
    ySample = 12'h123;
    zSample = 12'hf0f;
    nErrors = 0;
    cmpCount = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    chkDefaults();
    chk("status", ADDR_CONDITION_FLAGS, 8'hff, 8'hc0);
    cmp("pins", 8'h00, {6'h00, irqPin2, irqPin1});
    chk("revision", ADDR_SILICON_REVISION, 8'hff, REV_CODE);
    u_host.wr(ADDR_VENDOR_CODE, 8'h00);
    chk("vendor", ADDR_VENDOR_CODE, 8'hff, VEND_CODE);
    chk("unmapped", 8'h05, 8'hff, 8'h00);
    chk("status", ADDR_CONDITION_FLAGS, 8'h80, 8'h00);
    // Pattern keeps the measure field at standby
    for (int a = 32; a <= 46; a++) u_host.wr(8'(a), 8'(a) ^ 8'hc5);
    for (int a = 32; a <= 46; a++) begin
      regInfo(8'(a));
      chk("readback", 8'(a), 8'hff, (8'(a) ^ 8'hc5) & msk);
    end
    u_host.wr(ADDR_SOFTWARE_RESET, SOFT_RESET_CODE);
    chk("soft reset", ADDR_SOFTWARE_RESET, 8'hff, 8'h00);
    chk("status", ADDR_CONDITION_FLAGS, 8'h80, 8'h80);
    chkDefaults();
    for (int i = 0; i < 3; i++) begin
      u_host.wr(ADDR_DETECTION_CONTROL, 8'(i << 4));
      chk("awake", ADDR_CONDITION_FLAGS, 8'h40, (i == 0) ? 8'h40 : 8'h00);
    end
    @(posedge core_clk);
    awakeState <= 1'b1;
    chk("awake", ADDR_CONDITION_FLAGS, 8'h40, 8'h40);
    pulse(0);
    chk("ready", ADDR_CONDITION_FLAGS, 8'h01, 8'h01);
    chk("x axis", ADDR_X_AXIS_BYTE, 8'hff, 8'hab);
    chk("y axis", ADDR_Y_AXIS_BYTE, 8'hff, 8'h12);
    chk("z axis", ADDR_Z_AXIS_BYTE, 8'hff, 8'hf0);
    pulse(1);
    chk("ready", ADDR_CONDITION_FLAGS, 8'h01, 8'h00);
    for (int i = 2; i <= 4; i++) begin
      pulse(i);
      chk("event", ADDR_CONDITION_FLAGS, 8'h38, 8'h08 << (i - 2));
    end
    u_host.wr(ADDR_BUFFER_CONTROL, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      bufferCount <= cnts[i];
      chk("buffer", ADDR_CONDITION_FLAGS, 8'h06, lvl[i]);
    end
    chk("status", ADDR_CONDITION_FLAGS, 8'h80, 8'h00);
    pulse(5);
    chk("upset", ADDR_CONDITION_FLAGS, 8'h80, 8'h80);
    u_host.wr(ADDR_IRQ_PIN1_MAP, 8'h01);
    u_host.wr(ADDR_IRQ_PIN2_MAP, 8'h80);
    pulse(0);
    repeat (3) @(posedge core_clk);
    #1;
    cmp("pins", 8'h03, {6'h00, irqPin2, irqPin1});
    test_done();
  end
endmodule
